/* File: inc/ncdp_pkg.sv */
// Shared constants, slot encoding and opcodes for the nibble processor core.
package ncdp_pkg;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          ADDR_W           = 12;
    localparam int          STACK_DEPTH      = 4;
    localparam int          IDX_WORDS        = 16;
    localparam int          CYCLE_CLOCKS     = 8;
    localparam int          DOUBLE_CLOCKS    = 16;
    localparam int          RESET_HOLD_CLKS  = 64;
    localparam int          REFRESH_W        = 6;
    localparam logic [3:0]  NIB_ZERO         = 4'h0;
    localparam logic [2:0]  CMD_RESET        = 3'h0;
    localparam logic [3:0]  RAM_LINE0        = 4'h1;
    localparam logic [3:0]  BCD_LIMIT        = 4'h9;
    localparam logic [3:0]  BCD_FIX          = 4'h6;
    localparam logic [3:0]  KBP_BAD          = 4'hf;

    typedef enum logic [7:0] {
        SA1 = 8'h01, SA2 = 8'h02, SA3 = 8'h04, SM1 = 8'h08,
        SM2 = 8'h10, SX1 = 8'h20, SX2 = 8'h40, SX3 = 8'h80
    } ncdp_slot_e;

    localparam logic [3:0] OP_COND_JUMP = 4'h1;
    localparam logic [3:0] OP_PAIR      = 4'h2;
    localparam logic [3:0] OP_INDIRECT  = 4'h3;
    localparam logic [3:0] OP_JUMP      = 4'h4;
    localparam logic [3:0] OP_CALL      = 4'h5;
    localparam logic [3:0] OP_INC       = 4'h6;
    localparam logic [3:0] OP_INC_SKIP  = 4'h7;
    localparam logic [3:0] OP_ADD       = 4'h8;
    localparam logic [3:0] OP_SUB       = 4'h9;
    localparam logic [3:0] OP_LOAD      = 4'ha;
    localparam logic [3:0] OP_XCHG      = 4'hb;
    localparam logic [3:0] OP_RETURN    = 4'hc;
    localparam logic [3:0] OP_LOAD_IMM  = 4'hd;
    localparam logic [3:0] OP_IO_GROUP  = 4'he;
    localparam logic [3:0] OP_ACC_GROUP = 4'hf;

    localparam logic [3:0] IO_SUB_MEM   = 4'h8;
    localparam logic [3:0] IO_ADD_MEM   = 4'hb;

    localparam logic [3:0] AG_CLB = 4'h0;
    localparam logic [3:0] AG_CLC = 4'h1;
    localparam logic [3:0] AG_IAC = 4'h2;
    localparam logic [3:0] AG_CMC = 4'h3;
    localparam logic [3:0] AG_CMA = 4'h4;
    localparam logic [3:0] AG_RAL = 4'h5;
    localparam logic [3:0] AG_RAR = 4'h6;
    localparam logic [3:0] AG_TCC = 4'h7;
    localparam logic [3:0] AG_DAC = 4'h8;
    localparam logic [3:0] AG_TCS = 4'h9;
    localparam logic [3:0] AG_STC = 4'ha;
    localparam logic [3:0] AG_DAA = 4'hb;
    localparam logic [3:0] AG_KBP = 4'hc;
    localparam logic [3:0] AG_DCL = 4'hd;
endpackage : ncdp_pkg

/* File: inc/ncdp_inc_if.sv */
// Connection between the core and a nibble carry look-ahead incrementer.
`timescale 1ns/1ps
interface ncdp_inc_if;
    logic [3:0] nib;
    logic       cin;
    logic [3:0] sum;
    logic       cout;
    modport user (output nib, output cin, input sum, input cout);
    modport unit (input nib, input cin, output sum, output cout);
endinterface : ncdp_inc_if

/* File: core/ncdp_inc.sv */
// Nibble incrementer with carry look-ahead.
`timescale 1ns/1ps
module ncdp_inc (
    ncdp_inc_if.unit port
);
    logic [3:0] carry;

    // All carries come from the same input term, so no ripple path exists.
    assign carry[0] = port.cin;
    assign carry[1] = port.cin & port.nib[0];
    assign carry[2] = port.cin & port.nib[0] & port.nib[1];
    assign carry[3] = port.cin & port.nib[0] & port.nib[1] & port.nib[2];
    assign port.sum  = port.nib ^ carry;
    assign port.cout = carry[3] & port.nib[3];
endmodule : ncdp_inc

/* File: core/ncdp_core.sv */
// Nibble processor core: address stack, index file, adder and decoder.
// Functional notes
// - Four 12-bit address entries: one program counter, three return levels.
// - Current address goes out as three nibbles in the first three slots.
// - Each sent slice is incremented with look-ahead carry and written back.
// - Sixteen nibble index file, usable as singles or eight pairs.
// - Modifier selects one of sixteen, or a pair by its upper three bits.
// - Even pair member holds upper nibble, odd member holds lower.
// - Index read through a multiplexer; writes pass through a temporary register.
// - Ripple adder sums operand buffer, true or inverted, with accumulator and carry.
// - Accumulator shifter rotates left and right through the carry.
// - Three-bit command code from accumulator picks the RAM bank line.
// - Fixed tables convert accumulator for decimal adjust and keypad code.
// - Condition logic senses zero result, zero accumulator, carry and test input.
// - Condition flip-flop decides conditional jump and skip-if-zero outcome.
// - Opcode nibble latched in first fetch slot, modifier in second.
// - Word is opcode in upper nibble, modifier in lower nibble.
// - Single word takes eight clocks, double word sixteen over two locations.
// - Five double-length opcodes set the double-cycle flip-flop.
// - Second word is a middle and low address or eight data bits.
// - Group opcode picks I/O or accumulator group, modifier picks the operation.
// - Reset clears state and drives zero on the bus; start at address zero.
// - Cycle-start marker once every eight clocks.
// - Call pushes one level, return pops one; a fourth call loses the oldest.
// - RAM bank line zero is selected after reset.
`timescale 1ns/1ps
module ncdp_core #(
    parameter int ADDR_W = ncdp_pkg::ADDR_W
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [3:0] dataIn,
    input  wire logic       testIn,
    output logic      [3:0] dataOut,
    output logic            dataOe_b,
    output logic            syncOut,
    output logic            romCmdLine,
    output logic      [3:0] ramBankCmdLine,
    output logic      [3:0] accValue,
    output logic            carryFlag
);
    if (ADDR_W != 12) begin : g_bad_width
        $error("ncdp_core supports only a 12-bit address.");
    end

    ncdp_pkg::ncdp_slot_e slot_q;
    logic [ADDR_W-1:0]    addr_q [ncdp_pkg::STACK_DEPTH];
    logic [3:0]           idx_q  [ncdp_pkg::IDX_WORDS];
    logic [1:0]           sp_q;
    logic [3:0]           opr_q, opa_q, w2hi_q, w2lo_q;
    logic [3:0]           acc_q, adb_q, temp_q;
    logic                 cy_q, cond_q, dbl_q, incCy_q;
    logic [2:0]           cmd_q;
    logic [3:0]           accD;
    logic                 cyD;

    ncdp_inc_if pcInc ();
    ncdp_inc_if idxInc ();
    ncdp_inc u_pc_inc (.port(pcInc.unit));
    ncdp_inc u_idx_inc (.port(idxInc.unit));

    wire sA1 = slot_q == ncdp_pkg::SA1;
    wire sA2 = slot_q == ncdp_pkg::SA2;
    wire sA3 = slot_q == ncdp_pkg::SA3;
    wire sM1 = slot_q == ncdp_pkg::SM1;
    wire sM2 = slot_q == ncdp_pkg::SM2;
    wire sX1 = slot_q == ncdp_pkg::SX1;
    wire sX2 = slot_q == ncdp_pkg::SX2;
    wire sX3 = slot_q == ncdp_pkg::SX3;
    wire first = !dbl_q;

    // Instruction decode from the latched opcode and modifier nibbles.
    wire isJcn  = opr_q == ncdp_pkg::OP_COND_JUMP;
    wire isFim  = opr_q == ncdp_pkg::OP_PAIR && !opa_q[0];
    wire isSrc  = opr_q == ncdp_pkg::OP_PAIR && opa_q[0];
    wire isJin  = opr_q == ncdp_pkg::OP_INDIRECT && opa_q[0];
    wire isJun  = opr_q == ncdp_pkg::OP_JUMP;
    wire isJms  = opr_q == ncdp_pkg::OP_CALL;
    wire isInc  = opr_q == ncdp_pkg::OP_INC;
    wire isIsz  = opr_q == ncdp_pkg::OP_INC_SKIP;
    wire isAdd  = opr_q == ncdp_pkg::OP_ADD;
    wire isSub  = opr_q == ncdp_pkg::OP_SUB;
    wire isLd   = opr_q == ncdp_pkg::OP_LOAD;
    wire isXch  = opr_q == ncdp_pkg::OP_XCHG;
    wire isBbl  = opr_q == ncdp_pkg::OP_RETURN;
    wire isLdm  = opr_q == ncdp_pkg::OP_LOAD_IMM;
    wire isDouble = isJcn | isFim | isJun | isJms | isIsz;
    wire ioRd   = first && opr_q == ncdp_pkg::OP_IO_GROUP && opa_q[3];
    wire ioWr   = first && opr_q == ncdp_pkg::OP_IO_GROUP && !opa_q[3];
    wire accGrp = first && opr_q == ncdp_pkg::OP_ACC_GROUP;
    wire idxOp  = first & (isInc | isIsz | isAdd | isSub | isLd | isXch);
    wire tblOp  = accGrp & (opa_q == ncdp_pkg::AG_DAA | opa_q == ncdp_pkg::AG_KBP);
    wire srcOp  = first & isSrc;

    // Pair addresses drop the lowest modifier bit.
    wire [3:0] pairEven = {opa_q[3:1], 1'b0};
    wire [3:0] pairOdd  = {opa_q[3:1], 1'b1};
    wire [3:0] idxRd    = idx_q[opa_q];
    wire [ADDR_W-1:0] pcCur = addr_q[sp_q];

    // Fixed conversion tables for decimal adjust and keypad code.
    wire       bcdFix  = acc_q > ncdp_pkg::BCD_LIMIT || cy_q;
    wire [4:0] daaSum  = {1'b0, acc_q} + {1'b0, ncdp_pkg::BCD_FIX};
    logic [3:0] kbpOut;
    always_comb begin
        case (acc_q)
            4'h0:    kbpOut = 4'h0;
            4'h1:    kbpOut = 4'h1;
            4'h2:    kbpOut = 4'h2;
            4'h4:    kbpOut = 4'h3;
            4'h8:    kbpOut = 4'h4;
            default: kbpOut = ncdp_pkg::KBP_BAD;
        endcase
    end
    wire [3:0] daaOut = bcdFix ? daaSum[3:0] : acc_q;
    wire [3:0] tblOut = opa_q == ncdp_pkg::AG_DAA ? daaOut : kbpOut;

    // Internal bus: the selects are mutually exclusive by slot and opcode.
    wire selIn  = sM1 | sM2 | (sX2 & ioRd);
    wire selIdx = sX1 & idxOp;
    wire selAcc = sX2 & first & isXch;
    wire selTbl = sX3 & tblOp;
    wire [3:0] ibus = selIn  ? dataIn :
                      selIdx ? idxRd  :
                      selAcc ? acc_q  :
                      selTbl ? tblOut : ncdp_pkg::NIB_ZERO;

    // Adder operand in true or complemented form.
    wire subMode = isSub | (ioRd && opa_q == ncdp_pkg::IO_SUB_MEM)
                 | (accGrp && opa_q == ncdp_pkg::AG_DAC);
    wire addCin  = accGrp ? opa_q == ncdp_pkg::AG_IAC : (subMode ? !cy_q : cy_q);
    wire [3:0] addB  = subMode ? ~adb_q : adb_q;
    wire [4:0] addSum = {1'b0, acc_q} + {1'b0, addB} + {4'h0, addCin};

    // Condition logic inputs.
    wire accZero = acc_q == ncdp_pkg::NIB_ZERO;
    wire resZero = temp_q == ncdp_pkg::NIB_ZERO;
    wire jcnHit  = opa_q[3] ^ ((opa_q[2] & accZero) | (opa_q[1] & cy_q)
                 | (opa_q[0] & testIn));

    assign pcInc.nib  = sA1 ? pcCur[3:0] : (sA2 ? pcCur[7:4] : pcCur[11:8]);
    assign pcInc.cin  = sA1 ? 1'b1 : incCy_q;
    assign idxInc.nib = adb_q;
    assign idxInc.cin = 1'b1;

    // Program counter loads happen in X2 so that A1 output sees the new value.
    wire [ADDR_W-1:0] farTarget  = {opa_q, w2hi_q, w2lo_q};
    wire [ADDR_W-1:0] pageTarget = {pcCur[11:8], w2hi_q, w2lo_q};
    wire jumpFar  = sX2 & dbl_q & (isJun | isJms);
    wire jumpPage = sX2 & dbl_q & (isJcn | isIsz) & cond_q;
    wire jumpInd  = sX2 & first & isJin;
    wire [1:0] spPush = sp_q + 2'h1;
    wire [1:0] spPop  = sp_q - 2'h1;

    // Index write port fed only from the temporary register.
    wire idxWe = (sX3 & first & (isInc | isIsz | isXch)) | (dbl_q & isFim & (sM2 | sX1));
    wire [3:0] idxWa = !(dbl_q & isFim) ? opa_q : (sM2 ? pairEven : pairOdd);

    // Bus drive and command lines, computed for the coming slot.
    wire drv = sX3 | sA1 | sA2 | (sX1 & (srcOp | ioWr)) | (sX2 & srcOp);
    wire [3:0] outVal = sX3 ? pcCur[3:0] :
                        sA1 ? pcCur[7:4] :
                        sA2 ? pcCur[11:8] :
                        (sX1 & srcOp) ? idx_q[pairEven] :
                        (sX2 & srcOp) ? idx_q[pairOdd] : acc_q;
    wire cmdOn = sA2 | (sM1 & first & dataIn == ncdp_pkg::OP_IO_GROUP) | (sX1 & srcOp);
    wire [3:0] ramDec = cmd_q == ncdp_pkg::CMD_RESET ? ncdp_pkg::RAM_LINE0
                                                     : {cmd_q, 1'b0};

    always_comb begin
        accD = acc_q;
        cyD  = cy_q;
        if (isLd | isXch | (ioRd & !(opa_q == ncdp_pkg::IO_SUB_MEM |
                                    opa_q == ncdp_pkg::IO_ADD_MEM))) begin
            accD = adb_q;
        end else if (isAdd | isSub | ioRd) begin
            {cyD, accD} = addSum;
        end else if (isLdm | isBbl) begin
            accD = opa_q;
        end else if (accGrp) begin
            case (opa_q)
                ncdp_pkg::AG_CLB: begin accD = 4'h0; cyD = 1'b0; end
                ncdp_pkg::AG_CLC: cyD = 1'b0;
                ncdp_pkg::AG_IAC: {cyD, accD} = addSum;
                ncdp_pkg::AG_CMC: cyD = !cy_q;
                ncdp_pkg::AG_CMA: accD = ~acc_q;
                ncdp_pkg::AG_RAL: {cyD, accD} = {acc_q, cy_q};
                ncdp_pkg::AG_RAR: {accD, cyD} = {cy_q, acc_q};
                ncdp_pkg::AG_TCC: begin accD = {3'h0, cy_q}; cyD = 1'b0; end
                ncdp_pkg::AG_DAC: {cyD, accD} = addSum;
                ncdp_pkg::AG_TCS: begin accD = cy_q ? 4'ha : 4'h9; cyD = 1'b0; end
                ncdp_pkg::AG_STC: cyD = 1'b1;
                ncdp_pkg::AG_DAA: begin accD = ibus; cyD = cy_q | (bcdFix & daaSum[4]); end
                ncdp_pkg::AG_KBP: accD = ibus;
                default: ;
            endcase
        end
    end

    // Slot sequencer, fetch latches and double-cycle flip-flop.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            slot_q <= ncdp_pkg::SX3;
            dbl_q  <= 1'b0;
            opr_q  <= 4'h0;
            opa_q  <= 4'h0;
            w2hi_q <= 4'h0;
            w2lo_q <= 4'h0;
        end else begin
            slot_q <= ncdp_pkg::ncdp_slot_e'({slot_q[6:0], slot_q[7]});
            if (sM1 & first) opr_q <= ibus;
            if (sM2 & first) opa_q <= ibus;
            if (sM1 & dbl_q) w2hi_q <= ibus;
            if (sM2 & dbl_q) w2lo_q <= ibus;
            if (sX3) dbl_q <= first & isDouble;
        end
    end

    // Address array, stack pointer and slice incrementer.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sp_q    <= 2'h0;
            incCy_q <= 1'b0;
            // Every level is cleared at once, because a sweep counter without a
            // reset of its own would start unknown and never clear anything.
            for (int i = 0; i < ncdp_pkg::STACK_DEPTH; i++) begin
                addr_q[i] <= '0;
            end
        end else begin
            if (sA1 | sA2 | sA3) incCy_q <= pcInc.cout;
            if (sA1) addr_q[sp_q][3:0]  <= pcInc.sum;
            if (sA2) addr_q[sp_q][7:4]  <= pcInc.sum;
            if (sA3) addr_q[sp_q][11:8] <= pcInc.sum;
            if (jumpFar & isJms) begin
                sp_q <= spPush;
                addr_q[spPush] <= farTarget;
            end else if (jumpFar) begin
                addr_q[sp_q] <= farTarget;
            end else if (jumpPage) begin
                addr_q[sp_q] <= pageTarget;
            end else if (jumpInd) begin
                addr_q[sp_q][7:0] <= {idx_q[pairEven], idx_q[pairOdd]};
            end
            if (sX2 & first & isBbl) sp_q <= spPop;
        end
    end

    // Index file, cleared in one clock while reset is low.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            // The whole file clears in one clock, so any reset length empties it.
            for (int i = 0; i < ncdp_pkg::IDX_WORDS; i++) begin
                idx_q[i] <= 4'h0;
            end
        end else begin
            if (idxWe) idx_q[idxWa] <= temp_q;
        end
    end

    // Arithmetic registers, condition and command code.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            acc_q  <= 4'h0;
            cy_q   <= 1'b0;
            adb_q  <= 4'h0;
            temp_q <= 4'h0;
            cond_q <= 1'b0;
            cmd_q  <= ncdp_pkg::CMD_RESET;
        end else begin
            if (selIdx | (sX2 & ioRd)) adb_q <= ibus;
            else if (sX1 & accGrp) adb_q <= 4'h0;
            if (sX2 & first & (isInc | isIsz)) temp_q <= idxInc.sum;
            else if (selAcc | (dbl_q & isFim & (sM1 | sM2))) temp_q <= ibus;
            if (sX3 & first) begin
                acc_q <= accD;
                cy_q  <= cyD;
                if (isJcn) cond_q <= jcnHit;
                if (isIsz) cond_q <= !resZero;
                if (accGrp && opa_q == ncdp_pkg::AG_DCL) cmd_q <= acc_q[2:0];
            end
        end
    end

    // Registered pins.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            dataOut        <= 4'h0;
            dataOe_b       <= 1'b0;
            syncOut        <= 1'b0;
            romCmdLine     <= 1'b0;
            ramBankCmdLine <= 4'h0;
            accValue       <= 4'h0;
            carryFlag      <= 1'b0;
        end else begin
            dataOut        <= drv ? outVal : 4'h0;
            dataOe_b       <= !drv;
            syncOut        <= sX3;
            romCmdLine     <= cmdOn;
            ramBankCmdLine <= cmdOn ? ramDec : 4'h0;
            accValue       <= acc_q;
            carryFlag      <= cy_q;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    AST_SYNC_PERIOD: assert property (
        syncOut |=> !syncOut [*7] ##1 syncOut) else $error("Marker period is not 8.");
    AST_ADDR_OUT: assert property (
        sA1 |-> !dataOe_b && dataOut == pcCur[3:0]) else $error("A1 slice wrong.");
    AST_SLICE_INC: assert property (
        sA1 |=> addr_q[sp_q][3:0] == 4'($past(addr_q[sp_q][3:0]) + 4'h1))
        else $error("Low slice not incremented.");
    AST_RESET_START: assert property (
        $rose(rst_b) |-> sp_q == 2'h0 && addr_q[0] == '0 && $past(dataOut) == 4'h0)
        else $error("Reset state wrong.");
    AST_FETCH_ORDER: assert property (
        (sM2 && first) |-> opr_q == $past(dataIn) ##1 opa_q == $past(dataIn))
        else $error("Fetch order wrong.");
    AST_DOUBLE: assert property (
        (sX3 && first && isDouble) |=> dbl_q [*8] ##1 !dbl_q)
        else $error("Double cycle length wrong.");
    AST_BUS_ONE: assert property (
        $onehot0({selIn, selIdx, selAcc, selTbl})) else $error("Bus contention.");
    AST_CALL_PUSH: assert property (
        jumpFar && isJms |=> sp_q == 2'($past(sp_q) + 2'h1) && pcCur == $past(farTarget))
        else $error("Call push wrong.");
    AST_ADD: assert property (
        (sX3 && first && isAdd) |=> {cy_q, acc_q} == {1'b0, $past(acc_q)}
        + {1'b0, $past(adb_q)} + {4'h0, $past(cy_q)}) else $error("Add result wrong.");
    AST_DCL: assert property (
        (sX3 && accGrp && opa_q == ncdp_pkg::AG_DCL) |=> cmd_q == $past(acc_q[2:0]))
        else $error("Command code not loaded.");

    COV_CALL:  cover property (jumpFar && isJms);
    COV_JCN:   cover property (jumpPage && isJcn);
    COV_FIM:   cover property (idxWe && dbl_q && isFim);
    COV_RESET: cover property ($rose(rst_b));
endmodule : ncdp_core

/* File: test/ncdp_rom_model.sv */
// Behavioural program memory that answers the core on the shared nibble bus.
`timescale 1ns/1ps
module ncdp_rom_model (
    input  wire logic       ref_clk,
    input  wire logic       syncOut,
    input  wire logic [3:0] dataOut,
    output logic      [3:0] dataIn
);
    logic [7:0]  rom [0:31];
    logic [2:0]  slot;
    logic [11:0] fetchAddr;

    initial begin
        dataIn = 4'h0;
        slot   = 3'h7;
    end

    // Only the low five address bits select a word, so the program space wraps every 32.
    always @(negedge ref_clk) begin
        slot = syncOut ? 3'h0 : slot + 3'h1;
        case (slot)
            3'h0: fetchAddr[3:0]  = dataOut;
            3'h1: fetchAddr[7:4]  = dataOut;
            3'h2: fetchAddr[11:8] = dataOut;
            default: ;
        endcase
        if (slot == 3'h3) begin
            dataIn = rom[fetchAddr[4:0]][7:4];
        end else if (slot == 3'h4) begin
            dataIn = rom[fetchAddr[4:0]][3:0];
        end else begin
            // A released bus line keeps no value, so it toggles instead of holding.
            dataIn = ~dataIn;
        end
    end
endmodule : ncdp_rom_model

/* File: test/testbench.sv */
// Self-checking bench that runs a short program and checks the address and result stream.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
    logic       ref_clk = 1'b0;
    logic       rst_b   = 1'b0;
    logic       testIn  = 1'b1;
    logic [3:0] dataIn;
    logic [3:0] dataOut;
    logic       dataOe_b;
    logic       syncOut;
    logic       romCmdLine;
    logic [3:0] ramBankCmdLine;
    logic [3:0] accValue;
    logic       carryFlag;
    int         failures  = 0;
    int         cmp_count = 0;
    logic       first     = 1'b1;
    logic [7:0] prog [0:16] = '{8'hd5, 8'h20, 8'h3a, 8'h80, 8'h81, 8'hf5, 8'h40, 8'h08,
                                8'h50, 8'h10, 8'hfd, 8'h11, 8'h0e, 8'h00, 8'h40, 8'h0b, 8'hc7};
    localparam logic [3:0] L0 = ncdp_pkg::RAM_LINE0;

    always #(ncdp_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    ncdp_core u_ncdp_core (.ref_clk(ref_clk), .rst_b(rst_b), .dataIn(dataIn), .testIn(testIn),
        .dataOut(dataOut), .dataOe_b(dataOe_b), .syncOut(syncOut), .romCmdLine(romCmdLine),
        .ramBankCmdLine(ramBankCmdLine), .accValue(accValue), .carryFlag(carryFlag));
    ncdp_rom_model u_ncdp_rom_model (.ref_clk(ref_clk), .syncOut(syncOut),
        .dataOut(dataOut), .dataIn(dataIn));

    task print_verdict;
        $display("mismatches %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // Follows one instruction cycle from A1 to A3 and checks what the core shows there.
    task cyc(input logic [11:0] addr, input logic [3:0] acc, input logic cy, input logic [3:0] ram);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (syncOut !== 1'b1 && n < 20);
        if (n == 20) begin
            failures++;
            print_verdict();
        end
        if (!first) `CHK("sync spacing", 6, n)
        first = 1'b0;
        `CHK("addr low", addr[3:0], dataOut)
        `CHK("bus enable", 1'b0, dataOe_b)
        @(negedge ref_clk);
        `CHK("sync width", 1'b0, syncOut)
        `CHK("addr mid", addr[7:4], dataOut)
        @(negedge ref_clk);
        `CHK("addr high", addr[11:8], dataOut)
        `CHK("rom line", 1'b1, romCmdLine)
        `CHK("ram line", ram, ramBankCmdLine)
        `CHK("acc", acc, accValue)
        `CHK("carry", cy, carryFlag)
    endtask : cyc

    initial begin
        for (int i = 0; i < 32; i++) u_ncdp_rom_model.rom[i] = (i < 17) ? prog[i] : 8'h00;
        // Held for 70 clocks, though the first reset clock already clears every index entry.
        repeat (70) @(negedge ref_clk);
        `CHK("reset bus", 4'h0, dataOut)
        `CHK("reset drive", 1'b0, dataOe_b)
        `CHK("reset sync", 1'b0, syncOut)
        rst_b = 1'b1;
        cyc(12'h000, 4'h0, 1'b0, L0);
        cyc(12'h001, 4'h5, 1'b0, L0);
        cyc(12'h002, 4'h5, 1'b0, L0);
        cyc(12'h003, 4'h5, 1'b0, L0);
        cyc(12'h004, 4'h8, 1'b0, L0);
        cyc(12'h005, 4'h2, 1'b1, L0);
        cyc(12'h006, 4'h5, 1'b0, L0);
        cyc(12'h007, 4'h5, 1'b0, L0);
        cyc(12'h008, 4'h5, 1'b0, L0);
        cyc(12'h009, 4'h5, 1'b0, L0);
        cyc(12'h010, 4'h5, 1'b0, L0);
        cyc(12'h00a, 4'h7, 1'b0, L0);
        cyc(12'h00b, 4'h7, 1'b0, 4'he);
        cyc(12'h00c, 4'h7, 1'b0, 4'he);
        cyc(12'h00e, 4'h7, 1'b0, 4'he);
        cyc(12'h00f, 4'h7, 1'b0, 4'he);
        testIn = 1'b0;
        cyc(12'h00b, 4'h7, 1'b0, 4'he);
        cyc(12'h00c, 4'h7, 1'b0, 4'he);
        cyc(12'h00d, 4'h7, 1'b0, 4'he);
        cyc(12'h00e, 4'h7, 1'b0, 4'he);
        print_verdict();
    end
endmodule : testbench
